// file: verilog/pfm_pkg.sv
// Operation
// - supply lockout disables FETs, pump, logic
// - supply lockout recovers without any command
// - lockout exit latches power-on flag low
// - analog-rail undervoltage disables FETs, pump, logic
// - analog-rail recovery automatic, power-on flag low
// - buck undervoltage stops only buck FETs
// - buck undervoltage: pin low, buck flags set
// - buck recovery releases pin, flags stay
// - pump undervoltage: bridge off, pin low, auto recover
// - overvoltage acts only when enabled, auto recovers
// - overcurrent mode: latch, retry, report, ignore
// - fuse read error latches until sleep pulse
// - stall mode: latch, retry, report, ignore
// - thermal warning reported on pin only when enabled, flag always set
// - thermal shutdown: bridge off, auto recover
// - deglitched buck overcurrent: buck off, retry
package pfm_pkg;
    // ==========================================================
    // clock and times
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned RETRY_TIME_MS  = 5;
    localparam int unsigned STALL_RETRY_MS = 500;
    localparam int unsigned BK_RETRY_MS    = 5;
    localparam int unsigned BK_DEG_NS      = 2000;
    localparam int unsigned SLEEP_RST_US   = 20;
    localparam int unsigned RETRY_CYC       = RETRY_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned STALL_RETRY_CYC = STALL_RETRY_MS * (CLK_HZ / 1000);
    localparam int unsigned BK_RETRY_CYC    = BK_RETRY_MS * (CLK_HZ / 1000);
    localparam int unsigned BK_DEG_CYC      = (BK_DEG_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SLEEP_RST_CYC   = SLEEP_RST_US * (CLK_HZ / 1_000_000);

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADR_CHIP_STAT = 8'h00;
    localparam logic [7:0] ADR_FLAGS     = 8'h04;
    localparam logic [7:0] ADR_CTRL      = 8'h08;
    localparam logic [7:0] ADR_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] ADR_IRQ_MASK  = 8'h10;
    localparam logic [7:0] ADR_LIVE      = 8'h14;

    // ==========================================================
    // fault flag positions
    localparam int NFLAG     = 9;
    localparam int F_BUCK_UNDERVOLTAGE_FLAG = 0;
    localparam int F_PUMP_UV = 1;
    localparam int F_OVP     = 2;
    localparam int F_OCP     = 3;
    localparam int F_STALL   = 4;
    localparam int F_OTW     = 5;
    localparam int F_OTS     = 6;
    localparam int F_OTP     = 7;
    localparam int F_BUCK_OC = 8;

    // chip status bits
    localparam int CS_POR   = 0;
    localparam int CS_FAULT = 1;
    localparam int CS_BUCK  = 2;

    // control register fields
    localparam int CT_OV_EN   = 0;
    localparam int CT_OC_LO   = 1;
    localparam int CT_ST_LO   = 3;
    localparam int CT_OTW_EN  = 5;
    localparam int CT_CLR     = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // live state bits
    localparam int LV_HIZ   = 0;
    localparam int LV_BUCK  = 1;
    localparam int LV_LOGIC = 2;
    localparam int LV_FAULT = 3;

    // response selections
    localparam logic [1:0] RSP_LATCH  = 2'h0;
    localparam logic [1:0] RSP_RETRY  = 2'h1;
    localparam logic [1:0] RSP_REPORT = 2'h2;
    localparam logic [1:0] RSP_OFF    = 2'h3;
endpackage : pfm_pkg

// file: verilog/pfm_retry_timer.sv
`timescale 1ns/1ps
module pfm_retry_timer #(
    parameter int unsigned CYC = 16
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic start,
    output logic      busy
);
    localparam int W = $clog2(CYC + 1);

    // ==========================================================
    // parameter check
    if (CYC < 1) begin : g_bad_cyc
        $error("retry count must be at least one");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // load on start, count down to zero
    assign cnt_d = start ? W'(CYC) : ((cnt_q != '0) ? cnt_q - W'(1) : cnt_q);
    assign busy  = (cnt_q != '0);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : pfm_retry_timer

// file: verilog/pfm_fault_manager.sv
`timescale 1ns/1ps
module pfm_fault_manager
    import pfm_pkg::*;
#(
    parameter int unsigned RETRY_N       = RETRY_CYC,
    parameter int unsigned STALL_RETRY_N = STALL_RETRY_CYC,
    parameter int unsigned BK_RETRY_N    = BK_RETRY_CYC,
    parameter int unsigned BK_DEG_N      = BK_DEG_CYC,
    parameter int unsigned SLEEP_RST_N   = SLEEP_RST_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // qualified comparator indications
    input  wire logic        vm_uv_i,
    input  wire logic        avdd_uv_i,
    input  wire logic        buck_undervoltage_flag_i,
    input  wire logic        pump_uv_i,
    input  wire logic        ov_i,
    input  wire logic        oc_i,
    input  wire logic        stall_i,
    input  wire logic        otw_i,
    input  wire logic        otsd_i,
    input  wire logic        otp_err_i,
    input  wire logic        buck_oc_i,
    input  wire logic        sleep_pin_n,
    // actions
    output logic             fault_pin_n,
    output logic             bridge_hiz,
    output logic             buck_off,
    output logic             pump_off,
    output logic             logic_off
);
    localparam int DW = $clog2(BK_DEG_N + 1);
    localparam int SW = $clog2(SLEEP_RST_N + 1);

    // ==========================================================
    // parameter check
    if (BK_DEG_N < 1 || SLEEP_RST_N < 1) begin : g_bad_par
        $error("deglitch and sleep pulse counts must be at least one");
    end

    // ==========================================================
    // state
    logic             ack_q;
    logic [31:0]      rdat_q;
    logic [5:0]       ctrl_q;
    logic [5:0]       ctrl_d;
    logic [NFLAG-1:0] flag_q;
    logic [NFLAG-1:0] flag_d;
    logic [NFLAG-1:0] irq_q;
    logic [NFLAG-1:0] irq_d;
    logic [NFLAG-1:0] mask_q;
    logic             por_q;
    logic             por_d;
    logic             uv_prev_q;
    logic             oc_lat_q;
    logic             st_lat_q;
    logic [DW-1:0]    deg_q;
    logic [SW-1:0]    slp_q;
    logic             slp_prev_q;
    logic             pin_q;
    logic             hiz_q;
    logic             bk_q;
    logic             lg_q;

    // ==========================================================
    // bus decode
    logic        acc;
    logic        wr_en;
    logic [31:0] be_mask;
    logic [31:0] wdat;
    logic        wr_ctrl;
    logic        wr_flags;
    logic        wr_irq;
    logic        wr_mask;
    logic [31:0] rd_mux;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction : hit

    assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign be_mask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat     = wb_dat_i & be_mask;
    assign wr_ctrl  = wr_en & hit(wb_adr_i, ADR_CTRL);
    assign wr_flags = wr_en & hit(wb_adr_i, ADR_CHIP_STAT);
    assign wr_irq   = wr_en & hit(wb_adr_i, ADR_IRQ_STAT);
    assign wr_mask  = wr_en & hit(wb_adr_i, ADR_IRQ_MASK);

    // ==========================================================
    // control fields
    logic       ov_en;
    logic [1:0] oc_sel;
    logic [1:0] st_sel;
    logic       otw_en;
    logic       clr_cmd;

    assign ov_en   = ctrl_q[CT_OV_EN];
    assign oc_sel  = ctrl_q[CT_OC_LO +: 2];
    assign st_sel  = ctrl_q[CT_ST_LO +: 2];
    assign otw_en  = ctrl_q[CT_OTW_EN];
    // fault clear is a write-one pulse, never stored
    assign clr_cmd = wr_ctrl & wdat[CT_CLR];
    assign ctrl_d  = wr_ctrl ? wdat[5:0] : ctrl_q;

    // ==========================================================
    // sleep reset pulse: low long enough, then released
    logic sleep_clr;
    logic clr_any;

    assign sleep_clr = sleep_pin_n & ~slp_prev_q & (slp_q == SW'(SLEEP_RST_N));
    assign clr_any   = clr_cmd | sleep_clr;

    // ==========================================================
    // buck overcurrent deglitch
    logic bk_deg;

    assign bk_deg = buck_oc_i & (deg_q == DW'(BK_DEG_N));

    // ==========================================================
    // retry timers
    logic oc_busy;
    logic st_busy;
    logic bk_busy;
    logic oc_start;
    logic st_start;
    logic bk_start;

    assign oc_start = oc_i & (oc_sel == RSP_RETRY) & ~oc_busy;
    assign st_start = stall_i & (st_sel == RSP_RETRY) & ~st_busy;
    assign bk_start = bk_deg & ~bk_busy;

    pfm_retry_timer #(.CYC(RETRY_N)) u_oc_retry (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .start   (oc_start),
        .busy    (oc_busy)
    );

    pfm_retry_timer #(.CYC(STALL_RETRY_N)) u_st_retry (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .start   (st_start),
        .busy    (st_busy)
    );

    pfm_retry_timer #(.CYC(BK_RETRY_N)) u_bk_retry (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .start   (bk_start),
        .busy    (bk_busy)
    );

    // ==========================================================
    // fault flag set and clear vectors
    logic [NFLAG-1:0] set_v;
    logic [NFLAG-1:0] clr_v;
    logic [NFLAG-1:0] new_v;

    assign set_v[F_BUCK_UNDERVOLTAGE_FLAG] = buck_undervoltage_flag_i;
    assign set_v[F_PUMP_UV] = pump_uv_i;
    assign set_v[F_OVP]     = ov_i & ov_en;
    assign set_v[F_OCP]     = oc_i & (oc_sel != RSP_OFF);
    assign set_v[F_STALL]   = stall_i & (st_sel != RSP_OFF);
    assign set_v[F_OTW]     = otw_i;
    assign set_v[F_OTS]     = otsd_i;
    assign set_v[F_OTP]     = otp_err_i;
    assign set_v[F_BUCK_OC] = bk_deg;
    // fuse error flag only yields to the sleep pulse
    assign clr_v = {NFLAG{clr_any}} & ~(NFLAG'(!sleep_clr) << F_OTP);
    assign new_v = set_v & ~flag_q;

    // set wins over clear for every flag
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            assign flag_d[gi] = set_v[gi] | (flag_q[gi] & ~clr_v[gi]);
            assign irq_d[gi]  = new_v[gi] | (irq_q[gi] & ~(wr_irq & wdat[gi]));
        end
    endgenerate

    // ==========================================================
    // power-on flag, held low through and after lockout
    logic uv_any;
    logic uv_exit;

    assign uv_any  = vm_uv_i | avdd_uv_i;
    assign uv_exit = uv_prev_q & ~uv_any;
    assign por_d   = (uv_any | uv_exit) ? 1'b0 : (clr_any ? 1'b1 : por_q);

    // ==========================================================
    // latched shutdown and report holds
    logic oc_lat_d;
    logic st_lat_d;
    logic oc_latch_mode;
    logic st_latch_mode;

    assign oc_latch_mode = (oc_sel == RSP_LATCH) | (oc_sel == RSP_REPORT);
    assign st_latch_mode = (st_sel == RSP_LATCH) | (st_sel == RSP_REPORT);
    assign oc_lat_d = (oc_i & oc_latch_mode) | (oc_lat_q & ~(clr_any & ~oc_i));
    assign st_lat_d = (stall_i & st_latch_mode) | (st_lat_q & ~clr_any);

    // ==========================================================
    // actions
    logic oc_hiz;
    logic st_hiz;
    logic hiz_d;
    logic fault_d;
    logic bk_off_d;

    assign oc_hiz = (oc_sel == RSP_LATCH) & (oc_lat_q | oc_i)
                  | (oc_sel == RSP_RETRY) & (oc_i | oc_busy);
    assign st_hiz = (st_sel == RSP_LATCH) & (st_lat_q | stall_i)
                  | (st_sel == RSP_RETRY) & (stall_i | st_busy);
    // lockout states recover as soon as the supply returns
    assign hiz_d = uv_any
                 | pump_uv_i
                 | (ov_i & ov_en)
                 | oc_hiz | st_hiz
                 | otsd_i
                 | flag_q[F_OTP] | otp_err_i;
    // only the buck stage stops on buck faults
    assign bk_off_d = uv_any | buck_undervoltage_flag_i | bk_busy | bk_start;
    // pin follows live reported faults and held latches
    assign fault_d = buck_undervoltage_flag_i
                   | pump_uv_i
                   | (ov_i & ov_en)
                   | (oc_sel != RSP_OFF) & (oc_i | oc_lat_q | oc_busy)
                   | (st_sel != RSP_OFF) & (stall_i | st_lat_q | st_busy)
                   | (otw_i & otw_en)
                   | otsd_i
                   | flag_q[F_OTP] | otp_err_i
                   | bk_deg | bk_busy;

    // ==========================================================
    // read mux
    logic [31:0] chip_stat;
    logic [31:0] live;

    assign chip_stat = {29'h0, |flag_q[F_BUCK_UNDERVOLTAGE_FLAG] | flag_q[F_BUCK_OC], |flag_q, por_q};
    assign live      = {28'h0, ~pin_q, lg_q, bk_q, hiz_q};

    always_comb begin
        if (hit(wb_adr_i, ADR_CHIP_STAT)) begin
            rd_mux = chip_stat;
        end else if (hit(wb_adr_i, ADR_FLAGS)) begin
            rd_mux = {{(32-NFLAG){1'b0}}, flag_q};
        end else if (hit(wb_adr_i, ADR_CTRL)) begin
            rd_mux = {26'h0, ctrl_q};
        end else if (hit(wb_adr_i, ADR_IRQ_STAT)) begin
            rd_mux = {{(32-NFLAG){1'b0}}, irq_q};
        end else if (hit(wb_adr_i, ADR_IRQ_MASK)) begin
            rd_mux = {{(32-NFLAG){1'b0}}, mask_q};
        end else if (hit(wb_adr_i, ADR_LIVE)) begin
            rd_mux = live;
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // ==========================================================
    // bus registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RST;
            mask_q <= '0;
            irq_q  <= '0;
        end else begin
            ack_q  <= acc;
            rdat_q <= acc ? rd_mux : rdat_q;
            ctrl_q <= ctrl_d;
            mask_q <= wr_mask ? wdat[NFLAG-1:0] : mask_q;
            irq_q  <= irq_d;
        end
    end

    // ==========================================================
    // fault state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q    <= '0;
            por_q     <= 1'b0;
            uv_prev_q <= 1'b0;
            oc_lat_q  <= 1'b0;
            st_lat_q  <= 1'b0;
        end else begin
            flag_q    <= flag_d;
            por_q     <= por_d;
            uv_prev_q <= uv_any;
            oc_lat_q  <= oc_lat_d;
            st_lat_q  <= st_lat_d;
        end
    end

    // ==========================================================
    // deglitch and sleep pulse counters
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            deg_q      <= '0;
            slp_q      <= '0;
            slp_prev_q <= 1'b1;
        end else begin
            deg_q      <= !buck_oc_i ? '0 : ((deg_q == DW'(BK_DEG_N)) ? deg_q : deg_q + DW'(1));
            slp_q      <= sleep_pin_n ? (slp_prev_q ? '0 : slp_q)
                          : ((slp_q == SW'(SLEEP_RST_N)) ? slp_q : slp_q + SW'(1));
            slp_prev_q <= sleep_pin_n;
        end
    end

    // ==========================================================
    // output registers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= 1'b1;
            hiz_q <= 1'b1;
            bk_q  <= 1'b1;
            lg_q  <= 1'b1;
        end else begin
            pin_q <= ~fault_d;
            hiz_q <= hiz_d;
            bk_q  <= bk_off_d;
            lg_q  <= uv_any;
        end
    end

    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdat_q;
    assign irq_o       = |(irq_q & mask_q);
    assign fault_pin_n = pin_q;
    assign bridge_hiz  = hiz_q;
    assign buck_off    = bk_q;
    assign pump_off    = lg_q;
    assign logic_off   = lg_q;
endmodule : pfm_fault_manager

// file: verif/pfm_fault_manager_checker.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the fault manager
module pfm_fault_manager_checker
    import pfm_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        vm_uv_i,
    input wire logic        avdd_uv_i,
    input wire logic        buck_undervoltage_flag_i,
    input wire logic        pump_uv_i,
    input wire logic        ov_i,
    input wire logic        oc_i,
    input wire logic        otw_i,
    input wire logic        otsd_i,
    input wire logic        otp_err_i,
    input wire logic        sleep_pin_n,
    input wire logic        fault_pin_n,
    input wire logic        bridge_hiz,
    input wire logic        buck_off,
    input wire logic        pump_off,
    input wire logic        logic_off
);
    // lockout and control snoop
    logic [5:0] ctrl_q;
    wire        lk      = vm_uv_i | avdd_uv_i;
    wire        wr_ctrl = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i[7:2] == ADR_CTRL[7:2]);

    // copy of control fields, updated at the ack edge
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst)
            ctrl_q <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= wb_dat_i[5:0];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    AST_ACK_PULSE:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_ACK_AFTER:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_LOCK_OFF:
        assert property (lk |=> bridge_hiz && pump_off && logic_off) else $error("lockout left logic on");
    AST_LOCK_RESUME:
        assert property (lk ##1 !lk |=> !pump_off && !logic_off) else $error("no resume after lockout");
    AST_BUCK_UNDERVOLTAGE_FLAG:
        assert property (buck_undervoltage_flag_i && !lk |=> buck_off && !fault_pin_n) else $error("buck_undervoltage_flag not acted");
    AST_PUMP_UV:
        assert property (pump_uv_i && !lk |=> bridge_hiz && !fault_pin_n) else $error("pump uv not acted");
    AST_OV_EN:
        assert property (ov_i && ctrl_q[CT_OV_EN] && !lk |=> bridge_hiz && !fault_pin_n) else $error("ov not acted");
    AST_OC_REPORT:
        assert property (oc_i && ctrl_q[CT_OC_LO +: 2] == RSP_REPORT && !lk |=> !fault_pin_n) else $error("oc not reported");
    AST_OTP_HOLD:
        assert property (otp_err_i && !lk && sleep_pin_n |=> (bridge_hiz && !fault_pin_n)[*3]) else $error("fuse not held");
    AST_THERMAL_WARN_REPORT_EN:
        assert property (otw_i && ctrl_q[CT_OTW_EN] && !lk |=> !fault_pin_n) else $error("warning not reported");
    AST_OTSD:
        assert property (otsd_i && !lk |=> bridge_hiz && !fault_pin_n) else $error("shutdown not acted");

    // main scenarios reached
    COV_LOCK: cover property ($rose(logic_off));
    COV_OC:   cover property (oc_i ##1 bridge_hiz);
    COV_REP:  cover property (!fault_pin_n && !bridge_hiz && !buck_off);
endmodule : pfm_fault_manager_checker

// file: verif/pfm_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================
// external controller: bus master
module pfm_ctrl_model (
    input  wire logic        clk_sys,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    output logic             wb_cyc,
    output logic             wb_stb,
    output logic             wb_we,
    output logic      [7:0]  wb_adr,
    output logic      [3:0]  wb_sel,
    output logic      [31:0] wb_dat
);
    int tmo = 0;

    // idle bus at time zero
    initial begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we  = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
    end

    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        for (i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 32) tmo++;
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        wb_dat <= ~d;
    endtask : xfer
endmodule : pfm_ctrl_model

// file: verif/test_pfm_fault_manager.sv
`timescale 1ns/1ps
// ==========================================
// fault manager testbench
module test_pfm_fault_manager
    import pfm_pkg::*;
;
    localparam int unsigned RTY = 8;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sleep_pin_n = 1'b1;
    logic [10:0] flt = 11'h0;
    logic [31:0] cfg;
    logic [31:0] v;
    int          bad_count = 0;
    int          n_checks = 0;
    int          k;
    int          m;
    wire         wb_cyc, wb_stb, wb_we, wb_ack_o, irq_o;
    wire [7:0]   wb_adr;
    wire [3:0]   wb_sel;
    wire [31:0]  wb_dat, wb_dat_o;
    wire         fault_pin_n, bridge_hiz, buck_off, pump_off, logic_off;
    wire [4:0]   acts = {logic_off, pump_off, buck_off, bridge_hiz, ~fault_pin_n};

    always #20 clk_sys = ~clk_sys;

    pfm_fault_manager #(.RETRY_N(RTY), .STALL_RETRY_N(RTY), .BK_RETRY_N(RTY), .BK_DEG_N(3), .SLEEP_RST_N(4))
    i_pfm_fault_manager (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_o(irq_o), .vm_uv_i(flt[0]), .avdd_uv_i(flt[1]), .buck_undervoltage_flag_i(flt[2]),
        .pump_uv_i(flt[3]), .ov_i(flt[4]), .oc_i(flt[5]), .stall_i(flt[6]), .otw_i(flt[7]), .otsd_i(flt[8]),
        .otp_err_i(flt[9]), .buck_oc_i(flt[10]), .sleep_pin_n(sleep_pin_n), .fault_pin_n(fault_pin_n),
        .bridge_hiz(bridge_hiz), .buck_off(buck_off), .pump_off(pump_off), .logic_off(logic_off));

    pfm_ctrl_model i_pfm_ctrl_model (.clk_sys(clk_sys), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_dat(wb_dat));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task sense(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : sense

    task set(input int i, input logic b);
        @(posedge clk_sys);
        flt[i] <= b;
    endtask : set

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_pfm_ctrl_model.xfer(w, a, d, v);
        if (i_pfm_ctrl_model.tmo != 0) begin
            bad_count++;
            results();
        end
    endtask : bus

    task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, v, e);
    endtask : rdc

    task clr;
        bus(1'b1, ADR_CTRL, cfg | 32'h40);
    endtask : clr

    // sleep reset pulse longer than the minimum
    task slp;
        @(posedge clk_sys);
        sleep_pin_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        sleep_pin_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : slp

    // expected {hiz, pin low} for a response selection
    function automatic logic [4:0] rsp_exp(input logic [1:0] s, input bit late);
        rsp_exp = (s == RSP_OFF || (late && s == RSP_RETRY)) ? 5'h00 : {3'h0, s != RSP_REPORT, 1'b1};
    endfunction : rsp_exp

    task mode_run(input int i, input logic [1:0] s);
        if (i == 5) cfg[CT_OC_LO +: 2] = s;
        else cfg[CT_ST_LO +: 2] = s;
        bus(1'b1, ADR_CTRL, cfg);
        set(i, 1'b1);
        set(i, 1'b0);
        sense(1);
        chk("mode_hit", acts, rsp_exp(s, 1'b0));
        sense(3 * RTY);
        chk("mode_late", acts, rsp_exp(s, 1'b1));
        clr;
        sense(1);
        chk("mode_clr", acts, 5'h0);
    endtask : mode_run

    // pulse one fault input
    task onoff(input int i, input logic [4:0] e, input string nm);
        set(i, 1'b1);
        sense(1 + $urandom % 4);
        chk({nm, "_on"}, acts, e);
        set(i, 1'b0);
        sense(2);
        chk({nm, "_off"}, acts, 5'h0);
    endtask : onoff

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        results();
    end

    // main sequence
    initial begin
        void'($urandom(42));
        cfg = 32'h0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc(ADR_CHIP_STAT, 32'h0, "por_rst");
        rdc(ADR_LIVE, 32'h0, "live_rst");
        bus(1'b1, 8'h3c, 32'hffff_ffff);
        rdc(8'h3c, 32'h0, "unmapped");
        repeat (4) begin
            cfg = $urandom & 32'h3f;
            bus(1'b1, ADR_CTRL, cfg);
            rdc(ADR_CTRL, cfg, "ctrl_rw");
        end
        cfg = 32'h0;
        bus(1'b1, ADR_CTRL, cfg);
        clr;
        rdc(ADR_CHIP_STAT, 32'h1, "por_clr");
        for (k = 0; k < 2; k++) begin
            onoff(k, 5'h1e, "lock");
            rdc(ADR_CHIP_STAT, 32'h0, "por_low");
            slp;
            rdc(ADR_CHIP_STAT, 32'h1, "por_slp");
        end
        set(2, 1'b1);
        sense(2);
        chk("buv_on", acts, 5'h05);
        rdc(ADR_CHIP_STAT, 32'h7, "buv_stat");
        set(2, 1'b0);
        sense(2);
        chk("buv_off", acts, 5'h0);
        rdc(ADR_FLAGS, 32'h1, "buv_flag");
        rdc(ADR_CHIP_STAT, 32'h7, "buv_keep");
        clr;
        rdc(ADR_FLAGS, 32'h0, "buv_clr");
        onoff(3, 5'h03, "puv");
        rdc(ADR_FLAGS, 32'h2, "puv_flag");
        clr;
        for (k = 0; k < 2; k++) begin
            cfg[CT_OV_EN] = k[0];
            bus(1'b1, ADR_CTRL, cfg);
            onoff(4, k ? 5'h03 : 5'h00, "ov");
            clr;
        end
        for (k = 5; k < 7; k++)
            for (m = 0; m < 4; m++)
                mode_run(k, m[1:0]);
        set(9, 1'b1);
        sense(2);
        chk("otp_on", acts, 5'h03);
        set(9, 1'b0);
        clr;
        sense(2);
        chk("otp_hold", acts, 5'h03);
        slp;
        sense(1);
        chk("otp_slp", acts, 5'h0);
        for (k = 0; k < 2; k++) begin
            cfg[CT_OTW_EN] = k[0];
            bus(1'b1, ADR_CTRL, cfg);
            onoff(7, k ? 5'h01 : 5'h00, "otw");
            clr;
        end
        onoff(8, 5'h03, "ots");
        rdc(ADR_FLAGS, 32'h40, "ots_flag");
        clr;
        set(10, 1'b1);
        sense(2);
        set(10, 1'b0);
        sense(2);
        chk("boc_glitch", acts, 5'h0);
        set(10, 1'b1);
        sense(5);
        set(10, 1'b0);
        sense(1);
        chk("boc_on", acts, 5'h05);
        sense(3 * RTY);
        chk("boc_retry", acts, 5'h0);
        clr;
        bus(1'b1, ADR_IRQ_STAT, 32'h1ff);
        bus(1'b1, ADR_IRQ_MASK, 32'h40);
        sense(1);
        chk("irq_idle", irq_o, 1'b0);
        set(8, 1'b1);
        sense(2);
        chk("irq_set", irq_o, 1'b1);
        set(8, 1'b0);
        bus(1'b1, ADR_IRQ_MASK, 32'h0);
        sense(1);
        chk("irq_mask", irq_o, 1'b0);
        bus(1'b1, ADR_IRQ_MASK, 32'h40);
        sense(1);
        chk("irq_unmask", irq_o, 1'b1);
        bus(1'b1, ADR_IRQ_STAT, 32'h40);
        sense(1);
        chk("irq_w1c", irq_o, 1'b0);
        results();
    end
endmodule : test_pfm_fault_manager

bind pfm_fault_manager pfm_fault_manager_checker i_pfm_fault_manager_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .vm_uv_i(vm_uv_i), .avdd_uv_i(avdd_uv_i), .buck_undervoltage_flag_i(buck_undervoltage_flag_i),
    .pump_uv_i(pump_uv_i), .ov_i(ov_i), .oc_i(oc_i), .otw_i(otw_i), .otsd_i(otsd_i), .otp_err_i(otp_err_i),
    .sleep_pin_n(sleep_pin_n), .fault_pin_n(fault_pin_n), .bridge_hiz(bridge_hiz), .buck_off(buck_off),
    .pump_off(pump_off), .logic_off(logic_off));
